// ---- rtl/iotcc_pkg.sv ----
// Constants for the 16-bit timer with compare and capture channels.
// Assumes a single clock domain and the plain register port of iotcc_top.
package iotcc_pkg;
    localparam int NCMP = 6;
    localparam int NCAP = 4;
    // Register offsets (word index on the plain port)
    localparam logic [4:0] A_TCTL   = 5'h00;
    localparam logic [4:0] A_TCNT   = 5'h01;
    localparam logic [4:0] A_OCTL   = 5'h02;
    localparam logic [4:0] A_CCTL   = 5'h03;
    localparam logic [4:0] A_ISTAT  = 5'h04;
    localparam logic [4:0] A_IMASK  = 5'h05;
    localparam logic [4:0] A_CMP0   = 5'h08;
    localparam logic [4:0] A_CAP0   = 5'h10;
    // Timer control fields
    localparam int TC_DIV_LSB  = 0;
    localparam int TC_RUN      = 2;
    localparam int TC_CLRMODE  = 3;
    localparam int TC_CLR      = 4;
    // Output control fields: [5:0] enable, [11:6] preset level, [14:12] pair
    localparam int OC_EN_LSB   = 0;
    localparam int OC_LVL_LSB  = 6;
    localparam int OC_PAIR_LSB = 12;
    localparam int OC_LOAD     = 15;
    // Status bits: [5:0] compare, [9:6] capture, 10 overflow, 11 compare-0 match
    localparam int ST_CAP_LSB  = 6;
    localparam int ST_OVF      = 10;
    localparam int ST_MT0      = 11;
    localparam int ST_W        = 12;
    // Prescaler divisions
    localparam logic [5:0] DIV4  = 6'h03;
    localparam logic [5:0] DIV16 = 6'h0f;
    localparam logic [5:0] DIV32 = 6'h1f;
    localparam logic [5:0] DIV64 = 6'h3f;
    localparam logic [15:0] RST16 = 16'h0000;
endpackage

// ---- rtl/iotcc_top.sv ----
// Free-running timer, six compare outputs and four capture inputs.
// Assumes a bus master that keeps to one-cycle strobes, never both at once.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - 16-bit up counter clocked by prescaler dividing by 4, 16, 32 or 64.
// - Overflow raises interrupt; compare-0 match raises one when enabled.
// - Counter cleared on reset, software clear, or compare-0 match in clear mode.
// - Each compare channel sets its flag on match and toggles its own output latch unless paired.
// - Compare channels independent unless paired; each has own flag, and own pin when unpaired.
// - A channel pair may share one pin; a match of either alone toggles it, matches of both in one tick cancel.
// - Software presets each compare pin level before operation.
// - Capture copies counter on valid edge and raises interrupt.
// - Capture edge selectable per channel: rising, falling or both.
// - Capture request can start the autonomous transfer service.
module iotcc_top (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Register port
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Pins
    input  wire logic [3:0]  i_cap,
    output logic      [5:0]  o_cmp,
    // Requests
    output logic             o_irq,
    output logic      [3:0]  o_xfer_req
);
    typedef struct packed {
        logic [5:0]       pre;
        logic [15:0]      cnt;
        logic [4:0]       tctl;
        logic [15:0]      octl;
        logic [7:0]       cctl;
        logic [11:0]      stat;
        logic [11:0]      mask;
        logic [5:0][15:0] cmp;
        logic [3:0][15:0] cap;
        logic [5:0]       lat;
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       s3;
        logic [3:0]       lvl;
        logic [3:0]       xfer;
        logic [15:0]      rdata;
    } iotcc_st_t;

    iotcc_st_t st_r;
    iotcc_st_t st_nxt;

    // Prescaler terminal count for the selected division
    function automatic logic [5:0] div_sel(input logic [1:0] s);
        unique case (s)
            2'd0: div_sel = iotcc_pkg::DIV4;
            2'd1: div_sel = iotcc_pkg::DIV16;
            2'd2: div_sel = iotcc_pkg::DIV32;
            2'd3: div_sel = iotcc_pkg::DIV64;
        endcase
    endfunction

    // Compare word equal to the running count
    function automatic logic hit(input logic [15:0] word, input logic [15:0] cnt);
        hit = (word == cnt);
    endfunction

    // Address falls on one of the compare registers
    function automatic logic cmp_slot(input logic [4:0] addr);
        logic [4:0] off;
        off = addr - iotcc_pkg::A_CMP0;
        cmp_slot = (addr >= iotcc_pkg::A_CMP0) && (off < 5'(iotcc_pkg::NCMP));
    endfunction

    // Address falls on one of the capture registers
    function automatic logic cap_slot(input logic [4:0] addr);
        logic [4:0] off;
        off = addr - iotcc_pkg::A_CAP0;
        cap_slot = (addr >= iotcc_pkg::A_CAP0) && (off < 5'(iotcc_pkg::NCAP));
    endfunction

    // A filtered level change qualifies as a capture edge
    function automatic logic edge_ok(input logic [1:0] mode, input logic lvl_new);
        unique case (mode)
            2'd0: edge_ok = 1'b0;
            2'd1: edge_ok = lvl_new;
            2'd2: edge_ok = ~lvl_new;
            2'd3: edge_ok = 1'b1;
        endcase
    endfunction

    // Read multiplexer; unmapped words read as zero
    function automatic logic [15:0] read_word(input iotcc_st_t s, input logic [4:0] addr);
        read_word = 16'h0000;
        unique case (addr)
            iotcc_pkg::A_TCTL: read_word = {11'h000, s.tctl};
            iotcc_pkg::A_TCNT: read_word = s.cnt;
            iotcc_pkg::A_OCTL: read_word = {1'b0, s.octl[14:12], 6'h00, s.lat};
            iotcc_pkg::A_CCTL: read_word = {8'h00, s.cctl};
            iotcc_pkg::A_ISTAT: read_word = {4'h0, s.stat};
            iotcc_pkg::A_IMASK: read_word = {4'h0, s.mask};
            default: begin
                if (cmp_slot(addr)) begin
                    read_word = s.cmp[3'(addr - iotcc_pkg::A_CMP0)];
                end else if (cap_slot(addr)) begin
                    read_word = s.cap[2'(addr - iotcc_pkg::A_CAP0)];
                end
            end
        endcase
    endfunction

    logic        run;
    logic        tick;
    logic [5:0]  match;
    logic [5:0]  tog;
    logic [3:0]  edg;
    logic [11:0] ev;

    always_comb begin
        st_nxt = st_r;
        // Prescaler rests at zero while stopped, so the first period after a start is whole;
        // a smaller division set mid-count ticks at once instead of waiting for a wrap
        run = st_r.tctl[iotcc_pkg::TC_RUN];
        tick = run && (st_r.pre >= div_sel(st_r.tctl[iotcc_pkg::TC_DIV_LSB +: 2]));
        if (!run || tick) begin
            st_nxt.pre = 6'h00;
        end else begin
            st_nxt.pre = st_r.pre + 6'h01;
        end
        for (int i = 0; i < iotcc_pkg::NCMP; i++) begin
            match[i] = tick && hit(st_r.cmp[i], st_r.cnt)
                && st_r.octl[iotcc_pkg::OC_EN_LSB + i];
        end
        tog = match;
        for (int p = 0; p < 3; p++) begin
            if (st_r.octl[iotcc_pkg::OC_PAIR_LSB + p]) begin
                tog[2*p]   = match[2*p] ^ match[2*p+1];
                tog[2*p+1] = 1'b0;
            end
        end
        st_nxt.lat = st_r.lat ^ tog;
        if (tick) begin
            if (st_r.tctl[iotcc_pkg::TC_CLRMODE] && hit(st_r.cmp[0], st_r.cnt)) begin
                st_nxt.cnt = iotcc_pkg::RST16;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
            end
        end
        if (st_r.tctl[iotcc_pkg::TC_CLR]) begin
            st_nxt.cnt = iotcc_pkg::RST16;
            st_nxt.pre = 6'h00;
            st_nxt.tctl[iotcc_pkg::TC_CLR] = 1'b0;
        end
        // Capture pin filter: change accepted when stages two and three agree
        st_nxt.s1 = i_cap;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int c = 0; c < iotcc_pkg::NCAP; c++) begin
            edg[c] = 1'b0;
            if (st_r.s2[c] == st_r.s3[c] && st_r.s2[c] != st_r.lvl[c]) begin
                st_nxt.lvl[c] = st_r.s2[c];
                edg[c] = edge_ok(st_r.cctl[2*c +: 2], st_r.s2[c]);
            end
            if (edg[c]) begin
                st_nxt.cap[c] = st_r.cnt;
            end
        end
        st_nxt.xfer = edg & st_r.mask[iotcc_pkg::ST_CAP_LSB +: 4];
        ev = {tick && hit(st_r.cmp[0], st_r.cnt),
              tick && (st_r.cnt == 16'hffff), edg, match};
        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                iotcc_pkg::A_TCTL: st_nxt.tctl = i_wdata[4:0];
                iotcc_pkg::A_TCNT: st_nxt.cnt = i_wdata;
                iotcc_pkg::A_OCTL: begin
                    st_nxt.octl = i_wdata;
                    st_nxt.octl[iotcc_pkg::OC_LOAD] = 1'b0;
                    if (i_wdata[iotcc_pkg::OC_LOAD]) begin
                        st_nxt.lat = i_wdata[iotcc_pkg::OC_LVL_LSB +: 6];
                    end
                end
                iotcc_pkg::A_CCTL: st_nxt.cctl = i_wdata[7:0];
                iotcc_pkg::A_IMASK: st_nxt.mask = i_wdata[11:0];
                default: begin
                    if (cmp_slot(i_addr)) begin
                        st_nxt.cmp[3'(i_addr - iotcc_pkg::A_CMP0)] = i_wdata;
                    end
                end
            endcase
        end
        // Reads; data stand for the one cycle after the strobe
        st_nxt.rdata = 16'h0000;
        if (i_rd) begin
            st_nxt.rdata = read_word(st_r, i_addr);
        end
        // Sticky flags; an event in the clearing read cycle survives
        if (i_rd && i_addr == iotcc_pkg::A_ISTAT) begin
            st_nxt.stat = ev;
        end else begin
            st_nxt.stat = st_r.stat | ev;
        end
        if (!i_resetn) begin
            st_nxt = '0;
            st_nxt.cnt = iotcc_pkg::RST16;
            st_nxt.s1 = 4'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    assign o_rdata    = st_r.rdata;
    assign o_cmp      = st_r.lat;
    assign o_xfer_req = st_r.xfer;
    assign o_irq      = |(st_r.stat & st_r.mask);
endmodule

`default_nettype wire

// ---- tb/iotcc_pins.sv ----
// Pin model driving the four capture inputs.
// Assumes the bench names the wanted levels; pins move after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module iotcc_pins (
    // Clock and wanted levels
    input  wire logic       i_clk,
    input  wire logic [3:0] i_lvl,
    // Capture pins
    output logic      [3:0] o_cap
);
    initial o_cap = 4'h0;
    always @(posedge i_clk) o_cap <= i_lvl;
endmodule
`default_nettype wire

// ---- tb/iotcc_sva.sv ----
// Port checks for the timer block.
// Assumes one clock and the plain register port.
`timescale 1ns/100ps
`default_nettype none
module iotcc_sva (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [4:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [3:0]  i_cap,
    input wire logic [5:0]  o_cmp,
    input wire logic        o_irq,
    input wire logic [3:0]  o_xfer_req
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_clr;
        i_wr && i_addr == 5'h00 && i_wdata[4] && !i_wdata[2];
    endsequence
    sequence s_rdcnt;
        i_rd && i_addr == 5'h01;
    endsequence
    a_soft_clear: assert property (s_clr ##1 !i_wr ##1 s_rdcnt |=> o_rdata == 16'h0000)
        else $error("count not cleared");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside slot");
    a_unmapped_rd: assert property (i_rd && i_addr == 5'h1f |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_preset_load: assert property (i_wr && i_addr == 5'h02 && i_wdata[15] |=>
        o_cmp == $past(i_wdata[11:6]))
        else $error("preset not loaded");
    a_mask_off: assert property (i_wr && i_addr == 5'h05 && i_wdata == 16'h0000 |=> !o_irq)
        else $error("irq while masked");
    a_xfer_pulse: assert property ((o_xfer_req & $past(o_xfer_req)) == 4'h0)
        else $error("transfer request too long");
    a_cap_irq: assert property (o_xfer_req != 4'h0 |-> ##[0:1] o_irq)
        else $error("capture without irq");
    a_reset_quiet: assert property ($rose(i_resetn) |-> o_cmp == 6'h00 && !o_irq)
        else $error("outputs busy after reset");
endmodule
bind iotcc_top iotcc_sva u_sva (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cap(i_cap),
    .o_cmp(o_cmp), .o_irq(o_irq), .o_xfer_req(o_xfer_req));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the timer block.
// Assumes iotcc_top, the pin model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        i_clk, i_resetn, i_wr, i_rd, o_irq;
    logic [4:0]  i_addr;
    logic [15:0] i_wdata, o_rdata, v, a;
    logic [3:0]  i_cap, lvl, o_xfer_req, xs;
    logic [5:0]  o_cmp;
    int          n_errors = 0, cmp_count = 0, k;
    int          dv[4] = '{4, 16, 32, 64};
    iotcc_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cap(i_cap), .o_cmp(o_cmp),
        .o_irq(o_irq), .o_xfer_req(o_xfer_req));
    iotcc_pins u_pins (.i_clk(i_clk), .i_lvl(lvl), .o_cap(i_cap));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) xs <= i_resetn ? (xs | o_xfer_req) : 4'h0;
    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] ad, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic run(input logic [15:0] c);
        wr(5'h00, c);
        repeat (60) @(posedge i_clk);
        wr(5'h00, 16'h0000);
    endtask
    task automatic wirq;
        int j;
        for (j = 0; j < 50 && o_irq !== 1'b1; j++) begin
            @(posedge i_clk);
            #1;
        end
        if (j == 50) begin
            n_errors++;
            $display("[FAIL] %0t no interrupt request", $time);
            give_verdict();
        end
    endtask
    initial begin
        i_resetn = 1'b0;
        i_addr = 5'h00;
        i_wdata = 16'h0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        lvl = 4'h0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(5'h01, v);
        chk(v, 16'h0000);
        for (k = 0; k < 4; k++) begin
            wr(5'h00, 16'h0004 + 16'(k));
            rd(5'h01, a);
            repeat (3 * dv[k] - 2) @(posedge i_clk);
            rd(5'h01, v);
            chk(v - a, 16'h0003);
        end
        wr(5'h00, 16'h0000);
        wr(5'h01, 16'hfffd);
        wr(5'h05, 16'h0400);
        rd(5'h04, v);
        wr(5'h00, 16'h0004);
        wirq();
        rd(5'h04, v);
        chk(v & 16'h0400, 16'h0400);
        chk({15'h0000, o_irq}, 16'h0000);
        wr(5'h05, 16'h0000);
        wr(5'h00, 16'h0000);
        wr(5'h01, 16'h0000);
        for (k = 0; k < 6; k++) wr(5'h08 + 5'(k), 16'h0002 + 16'(k));
        wr(5'h02, 16'h8abf);
        chk({10'h000, o_cmp}, 16'h002a);
        rd(5'h04, v);
        run(16'h0004);
        chk({10'h000, o_cmp}, 16'h0015);
        rd(5'h04, v);
        chk(v, 16'h083f);
        wr(5'h01, 16'h0000);
        wr(5'h02, 16'h903f);
        run(16'h0004);
        rd(5'h02, v);
        chk(v, 16'h103c);
        wr(5'h01, 16'h0000);
        run(16'h000c);
        rd(5'h01, v);
        chk({15'h0000, v < 16'h0003}, 16'h0001);
        wr(5'h01, 16'h1234);
        wr(5'h00, 16'h0010);
        rd(5'h01, v);
        chk(v, 16'h0000);
        wr(5'h01, 16'h0abc);
        wr(5'h03, 16'h0039);
        wr(5'h05, 16'h03c0);
        rd(5'h04, v);
        lvl <= 4'hf;
        repeat (8) @(posedge i_clk);
        rd(5'h04, v);
        chk(v & 16'h03c0, 16'h0140);
        lvl <= 4'h0;
        repeat (8) @(posedge i_clk);
        rd(5'h04, v);
        chk(v & 16'h03c0, 16'h0180);
        chk({12'h000, xs}, 16'h0007);
        for (k = 0; k < 4; k++) begin
            wr(5'h10 + 5'(k), 16'h5555);
            rd(5'h10 + 5'(k), v);
            chk(v, k < 3 ? 16'h0abc : 16'h0000);
        end
        rd(5'h1f, v);
        chk(v, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
